// file: verilog/irq_master_ctrl.sv
`timescale 1ns/100ps
`include "irq_ctrl_map.svh"
// Contract
// RL1: latch timer and dma requests, show pending
// RL2: software write clears latched dma request
// RL3: timers share one bit; status names timer
// RL4: timer 0 beats 1, 1 beats 2
// RL5: fixed vector types per source
// RL6: hand out type times four
// RL7: equal priority resolved by source order
// RL8: external requests only in master mode
// RL9: per-input priority, mask, trigger select
// RL10: edge needs rise; level needs high
// RL11: source holds input low before rearm
// RL12: requester holds high until acknowledged
// RL13: direct request follows its input
// RL14: cascade: no type, two acknowledge pulses
// RL15: taking sets in-service, clears request
// RL16: in-service blocks same line unless nested
// RL17: internal vectoring: no acknowledge cycles, 42 clocks
// RL18: response 42 to 55 clocks, stretches
// RL19: two locked cycles, two idles between
// RL20: wait states until ready returns
// RL21: exclusive acknowledge pins, status lines driven
// RL22: external logic blocks bus stealing
// RL23: end-of-irq command clears in-service bit
module irq_master_ctrl #(
    parameter int RESP_INT_CLK  = `RESP_INT_CLK,
    parameter int CASC_TAIL_CLK = `CASC_TAIL_CLK
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    sys_rst_i,
    irq_link_if.dev                      link,
    input  wire logic [3:0]              reg_addr_i,
    input  wire logic [15:0]             reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic [15:0]                  reg_rdata_o,
    input  wire logic [2:0]              timer_evt_i,
    input  wire logic [1:0]              dma_evt_i,
    input  wire logic                    bus_busy_i,
    output logic                         vec_valid_o,
    output irq_ctrl_pkg::vec_addr_t      vec_addr_o,
    output irq_ctrl_pkg::vec_type_t      vec_type_o
);
    import irq_ctrl_pkg::*;
    initial begin
        if (RESP_INT_CLK < 1 || RESP_INT_CLK > 63 || CASC_TAIL_CLK < 1 || CASC_TAIL_CLK > 63)
            $error("response counts must lie in 1..63");
    end
    localparam logic [5:0] RESP_LOAD = 6'(RESP_INT_CLK - 1);
    localparam logic [5:0] TAIL_LOAD = 6'(CASC_TAIL_CLK - 1);
    localparam logic [5:0] ACK_LOAD  = 6'(`ACK_CYC_CLK - 1);
    localparam logic [5:0] GAP_LOAD  = 6'(`ACK_GAP_CLK - 1);
    // ----------------------------------------
    // state
    // ----------------------------------------
    ctl_t        ctl [7];
    logic [2:0]  pri_mask;
    logic        master;
    src_vec_t    in_service;
    logic [1:0]  dma_lat;
    logic [2:0]  tmr_stat;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  armed;
    resp_state_t state;
    resp_state_t next_state;
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic        cur_b;
    vec_type_t   cur_type;
    // ----------------------------------------
    // arbitration helper: lowest priority value, ties by index
    // ----------------------------------------
    function automatic logic [3:0] pick(input src_vec_t cand, input logic [20:0] pris);
        logic [3:0] best;
        logic [2:0] bp;
        best = 4'h0;
        bp   = 3'h7;
        for (int i = 0; i < 7; i++) begin
            if (cand[i] && (!best[3] || pris[i*3 +: 3] < bp)) begin
                best = {1'b1, 3'(i)};
                bp   = pris[i*3 +: 3];
            end
        end
        return best;
    endfunction
    // ----------------------------------------
    // external inputs
    // ----------------------------------------
    wire [3:0] pin_in = {link.ext_irq_in_d, link.ext_irq_in_c,
                         link.ext_irq_in_b, link.ext_irq_in_a};
    wire       casc_a = ctl[`SRC_EXT_A][`CTL_CASCADE];
    wire       casc_b = ctl[`SRC_EXT_B][`CTL_CASCADE];
    // c and d pins turn into acknowledge outputs under cascade
    wire [3:0] pin_ok = {~casc_b, ~casc_a, 2'b11};
    logic [3:0] ext_req;
    logic [3:0] ext_level;
    logic [20:0] pris;
    src_vec_t   eligible;
    src_vec_t   src_req;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ext_level[i] = ctl[i+3][`CTL_LEVEL];
            // not latched: request drops with the input  [RL10] [RL13] [RL8]
            ext_req[i]   = master & pin_ok[i] & sync2[i] & (ext_level[i] | armed[i]);
        end
    end
    // all three timers share bit zero  [RL1] [RL3]
    assign src_req = {ext_req, dma_lat, |tmr_stat};
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pris[i*3 +: 3] = ctl[i][`CTL_PRI_MSB:`CTL_PRI_LSB];
            // nested mode only on inputs a and b  [RL16] [RL9]
            eligible[i] = src_req[i] & ~ctl[i][`CTL_MASK]
                        & (ctl[i][`CTL_PRI_MSB:`CTL_PRI_LSB] <= pri_mask)
                        & (~in_service[i] | ((i == 3 || i == 4) & ctl[i][`CTL_SPECIAL_NESTED_SELECT]));
        end
    end
    wire [3:0] sel      = pick(eligible, pris);   // [RL7]
    wire [2:0] sel_idx  = sel[2:0];
    wire       take     = (state == ST_IDLE) & sel[3];
    wire [6:0] take_vec = take ? 7'(7'h01 << sel_idx) : 7'h00;
    // timer 0 first, then 1, then 2  [RL4]
    wire [1:0] tmr_idx  = tmr_stat[0] ? 2'h0 : (tmr_stat[1] ? 2'h1 : 2'h2);
    wire [2:0] tmr_clr  = (take && sel_idx == `SRC_TMR) ? 3'(3'h1 << tmr_idx) : 3'h0;
    wire       sel_casc = (sel_idx == `SRC_EXT_A && casc_a) || (sel_idx == `SRC_EXT_B && casc_b);
    // fixed type table  [RL5]
    wire vec_type_t int_type =
        (sel_idx == `SRC_TMR)   ? (tmr_idx == 2'h0 ? `VT_TMR0 :
                                   tmr_idx == 2'h1 ? `VT_TMR1 : `VT_TMR2) :
        (sel_idx == `SRC_DMA0)  ? `VT_DMA0 :
        (sel_idx == `SRC_DMA1)  ? `VT_DMA1 :
        (sel_idx == `SRC_EXT_A) ? `VT_EXT_A :
        (sel_idx == `SRC_EXT_B) ? `VT_EXT_B :
        (sel_idx == `SRC_EXT_C) ? `VT_EXT_C : `VT_EXT_D;
    // ----------------------------------------
    // register port decode
    // ----------------------------------------
    wire       wr_req  = reg_wr_i && reg_addr_i == `REG_REQUEST;
    wire       wr_is   = reg_wr_i && reg_addr_i == `REG_IN_SERVICE;
    wire       wr_pm   = reg_wr_i && reg_addr_i == `REG_PRI_MASK;
    wire       wr_ts   = reg_wr_i && reg_addr_i == `REG_TIMER_STAT;
    wire       wr_eoi  = reg_wr_i && reg_addr_i == `REG_EOI;
    wire       wr_mode = reg_wr_i && reg_addr_i == `REG_MODE;
    wire       in_ctl  = reg_addr_i >= `REG_CTL_BASE && reg_addr_i <= `REG_CTL_LAST;
    wire [2:0] ctl_idx = 3'(reg_addr_i - `REG_CTL_BASE);
    wire       wr_ctl  = reg_wr_i && in_ctl;
    // nonspecific end-of-irq clears the highest in-service source
    wire [3:0] eoi_top = pick(in_service, pris);
    wire [6:0] eoi_clr = !wr_eoi ? 7'h00 :
                         reg_wdata_i[`EOI_NONSPEC] ? (eoi_top[3] ? 7'(7'h01 << eoi_top[2:0]) : 7'h00) :
                         7'(7'h01 << reg_wdata_i[2:0]);
    wire [15:0] rd_mux =
        (reg_addr_i == `REG_REQUEST)    ? {9'h000, src_req} :
        (reg_addr_i == `REG_IN_SERVICE) ? {9'h000, in_service} :
        (reg_addr_i == `REG_PRI_MASK)   ? {13'h0000, pri_mask} :
        (reg_addr_i == `REG_TIMER_STAT) ? {13'h0000, tmr_stat} :
        in_ctl                          ? {9'h000, ctl[ctl_idx]} :
        (reg_addr_i == `REG_MODE)       ? {15'h0000, master} :
        (reg_addr_i == `REG_LAST_VEC)   ? {6'h00, vec_addr_o} : 16'h0000;
    // ----------------------------------------
    // response sequencer
    // ----------------------------------------
    wire count_run = !bus_busy_i;   // bus activity stretches the idle clocks  [RL18]
    wire fire      = (state == ST_RESP || state == ST_TAIL) && count_run && cnt == 6'h00;
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = sel_casc ? ST_ACK1 : ST_RESP;   // [RL14] [RL17]
                    next_cnt   = sel_casc ? ACK_LOAD : RESP_LOAD;
                end
            end
            ST_RESP, ST_TAIL: begin
                if (count_run) begin
                    next_state = (cnt == 6'h00) ? ST_IDLE : state;
                    next_cnt   = (cnt == 6'h00) ? 6'h00 : 6'(cnt - 6'h01);
                end
            end
            ST_ACK1: begin
                if (cnt != 6'h00) begin
                    next_cnt = 6'(cnt - 6'h01);
                end else if (link.ack_ready) begin   // [RL20]
                    next_state = ST_GAP;   // [RL19]
                    next_cnt   = GAP_LOAD;
                end
            end
            ST_GAP: begin
                next_state = (cnt == 6'h00) ? ST_ACK2 : ST_GAP;
                next_cnt   = (cnt == 6'h00) ? ACK_LOAD : 6'(cnt - 6'h01);
            end
            ST_ACK2: begin
                if (cnt != 6'h00) begin
                    next_cnt = 6'(cnt - 6'h01);
                end else if (link.ack_ready) begin   // [RL20]
                    next_state = ST_TAIL;
                    next_cnt   = TAIL_LOAD;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = 6'h00;
            end
        endcase
    end
    wire in_ack = state == ST_ACK1 || state == ST_ACK2;
    // one pulse pin at a time, chosen by the taken line  [RL21] [RL14]
    assign link.cascade_ack_out_a = in_ack & ~cur_b;
    assign link.cascade_ack_out_b = in_ack & cur_b;
    assign link.cascade_ack_oe_a  = casc_a;
    assign link.cascade_ack_oe_b  = casc_b;
    assign link.bus_status_lines  = in_ack ? `STATUS_IRQ_ACK_CYCLE : `STATUS_PASSIVE;   // [RL21]
    assign link.ack_lock          = in_ack || state == ST_GAP;   // [RL19]
    wire latch_type = state == ST_ACK2 && cnt == 6'h00 && link.ack_ready;
    // ----------------------------------------
    // flip-flops
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 7; i++) ctl[i] <= `CTL_RESET;
            pri_mask <= `PRI_MASK_RESET;
            master   <= 1'b0;
        end else begin
            if (wr_ctl) ctl[ctl_idx] <= reg_wdata_i[6:0];
            if (wr_pm) pri_mask <= reg_wdata_i[2:0];
            if (wr_mode) master <= reg_wdata_i[`MODE_MASTER];
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            in_service <= 7'h00;
            dma_lat    <= 2'h0;
            tmr_stat   <= 3'h0;
        end else begin
            // sets win over software and acknowledge clears  [RL15] [RL23] [RL2] [RL1]
            in_service <= ((wr_is ? reg_wdata_i[6:0] : in_service) & ~eoi_clr) | take_vec;
            dma_lat    <= ((wr_req ? reg_wdata_i[2:1] : dma_lat) & ~take_vec[2:1]) | dma_evt_i;
            tmr_stat   <= ((wr_ts ? reg_wdata_i[2:0] : tmr_stat) & ~tmr_clr) | timer_evt_i; // [RL3]
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            armed <= 4'h0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            // a low clock rearms; taking disarms the edge input  [RL10] [RL11]
            armed <= (armed & ~take_vec[6:3]) | ~sync2;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state       <= ST_IDLE;
            cnt         <= 6'h00;
            cur_b       <= 1'b0;
            cur_type    <= 8'h00;
            vec_valid_o <= 1'b0;
            vec_addr_o  <= 10'h000;
            vec_type_o  <= 8'h00;
            reg_rdata_o <= 16'h0000;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            vec_valid_o <= fire;
            reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
            if (take) cur_b <= sel_idx == `SRC_EXT_B;
            if (take) cur_type <= int_type;
            if (latch_type) cur_type <= link.ack_type_data;   // [RL19]
            if (fire) begin
                vec_type_o <= cur_type;
                vec_addr_o <= {cur_type, 2'b00};   // [RL6]
            end
        end
    end
endmodule

// file: inc/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define REG_REQUEST     4'h0
`define REG_IN_SERVICE  4'h1
`define REG_PRI_MASK    4'h2
`define REG_TIMER_STAT  4'h3
`define REG_EOI         4'h4
`define REG_CTL_BASE    4'h5
`define REG_CTL_LAST    4'hB
`define REG_MODE        4'hC
`define REG_LAST_VEC    4'hD
// ----------------------------------------
// source index, in default priority order
// ----------------------------------------
`define SRC_TMR         3'h0
`define SRC_DMA0        3'h1
`define SRC_DMA1        3'h2
`define SRC_EXT_A       3'h3
`define SRC_EXT_B       3'h4
`define SRC_EXT_C       3'h5
`define SRC_EXT_D       3'h6
// ----------------------------------------
// control register fields and reset values
// ----------------------------------------
`define CTL_PRI_LSB     0
`define CTL_PRI_MSB     2
`define CTL_MASK        3
`define CTL_LEVEL       4
`define CTL_CASCADE     5
`define CTL_SPECIAL_NESTED_SELECT        6
`define CTL_RESET       7'h0f
`define PRI_MASK_RESET  3'h7
`define EOI_NONSPEC     15
`define MODE_MASTER     0
// ----------------------------------------
// fixed vector types
// ----------------------------------------
`define VT_TMR0         8'h08
`define VT_TMR1         8'h12
`define VT_TMR2         8'h13
`define VT_DMA0         8'h0a
`define VT_DMA1         8'h0b
`define VT_EXT_A        8'h0c
`define VT_EXT_B        8'h0d
`define VT_EXT_C        8'h0e
`define VT_EXT_D        8'h0f
// ----------------------------------------
// response timing, in cpu clocks
// ----------------------------------------
`define RESP_INT_CLK    42
`define ACK_CYC_CLK     4
`define ACK_GAP_CLK     2
`define CASC_TAIL_CLK   34
`define STATUS_PASSIVE  3'h7
`define STATUS_IRQ_ACK_CYCLE     3'h0
`endif

// file: inc/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RESP = 6'h02,
        ST_ACK1 = 6'h04,
        ST_GAP  = 6'h08,
        ST_ACK2 = 6'h10,
        ST_TAIL = 6'h20
    } resp_state_t;
    typedef logic [6:0] src_vec_t;
    typedef logic [6:0] ctl_t;
    typedef logic [7:0] vec_type_t;
    typedef logic [9:0] vec_addr_t;
endpackage

// file: inc/irq_link_if.sv
`timescale 1ns/100ps
interface irq_link_if;
    logic       ext_irq_in_a;
    logic       ext_irq_in_b;
    logic       ext_irq_src_c;
    logic       ext_irq_src_d;
    logic       cascade_ack_out_a;
    logic       cascade_ack_oe_a;
    logic       cascade_ack_out_b;
    logic       cascade_ack_oe_b;
    logic [2:0] bus_status_lines;
    logic       ack_lock;
    logic       ack_ready;
    logic [7:0] ack_type_data;
    wire        ext_irq_in_c;
    wire        ext_irq_in_d;
    // ----------------------------------------
    // shared pins: acknowledge output wins while enabled
    // ----------------------------------------
    assign ext_irq_in_c = cascade_ack_oe_a ? cascade_ack_out_a : ext_irq_src_c;
    assign ext_irq_in_d = cascade_ack_oe_b ? cascade_ack_out_b : ext_irq_src_d;
    modport dev (
        input  ext_irq_in_a, ext_irq_in_b, ext_irq_in_c, ext_irq_in_d,
        input  ack_ready, ack_type_data,
        output cascade_ack_out_a, cascade_ack_oe_a, cascade_ack_out_b, cascade_ack_oe_b,
        output bus_status_lines, ack_lock
    );
    modport far (
        output ext_irq_in_a, ext_irq_in_b, ext_irq_src_c, ext_irq_src_d,
        output ack_ready, ack_type_data,
        input  ext_irq_in_c, ext_irq_in_d, bus_status_lines, ack_lock
    );
endinterface

// file: verilog/irq_far_end.sv
`timescale 1ns/100ps
`include "irq_ctrl_map.svh"
module irq_far_end (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    irq_link_if.far                    link,
    input  wire logic [3:0]            direct_level_i,
    input  wire logic [1:0]            slave_req_i,
    input  wire irq_ctrl_pkg::vec_type_t slave_type_a_i,
    input  wire irq_ctrl_pkg::vec_type_t slave_type_b_i,
    input  wire logic                  ready_hold_i,
    output logic [1:0]                 slave_pend_o,
    output logic                       block_bus_o
);
    import irq_ctrl_pkg::*;
    logic [1:0] pend;
    logic [1:0] ack_prev;
    logic [1:0] second;
    vec_type_t  type_q;
    wire  [1:0] ack_now  = {link.ext_irq_in_d, link.ext_irq_in_c};
    wire  [1:0] ack_rise = ack_now & ~ack_prev;
    wire  [1:0] ack_fall = ~ack_now & ack_prev;
    // pending is released only when the second pulse ends
    wire  [1:0] done     = ack_fall & second;
    wire  [1:0] next_pend = slave_req_i | (pend & ~done);
    // ----------------------------------------
    // request pins
    // ----------------------------------------
    // cascaded slaves hold the line high until acknowledged  [RL12]
    assign link.ext_irq_in_a  = direct_level_i[0] | pend[0];
    assign link.ext_irq_in_b  = direct_level_i[1] | pend[1];
    assign link.ext_irq_src_c = direct_level_i[2];
    assign link.ext_irq_src_d = direct_level_i[3];
    // return ready unless a wait state is wanted  [RL20]
    assign link.ack_ready     = ~ready_hold_i;
    assign link.ack_type_data = type_q;
    assign slave_pend_o       = pend;
    // bus requests are fenced off while the pair is locked  [RL22]
    assign block_bus_o        = link.ack_lock;
    // ----------------------------------------
    // acknowledge pair tracking
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pend     <= 2'h0;
            ack_prev <= 2'h0;
            second   <= 2'h0;
            type_q   <= 8'h00;
        end else begin
            pend     <= next_pend;
            ack_prev <= ack_now;
            second   <= (second ^ ack_fall) & pend;
            // type goes out on the second pulse only  [RL19]
            if (ack_rise[0] && second[0]) begin
                type_q <= slave_type_a_i;
            end else if (ack_rise[1] && second[1]) begin
                type_q <= slave_type_b_i;
            end
        end
    end
endmodule

// file: testbench/irq_link_asserts.sv
`timescale 1ns/100ps
module irq_link_asserts (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       cascade_ack_out_a,
    input  wire logic       cascade_ack_oe_a,
    input  wire logic       cascade_ack_out_b,
    input  wire logic       cascade_ack_oe_b,
    input  wire logic [2:0] bus_status_lines,
    input  wire logic       ack_lock,
    input  wire logic       ack_ready
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire ack_any = cascade_ack_out_a | cascade_ack_out_b;
    // ----------------------------------------
    // acknowledge sequence pieces
    // ----------------------------------------
    sequence s_ack_a;
        cascade_ack_out_a [*4];
    endsequence
    sequence s_ack_b;
        cascade_ack_out_b [*4];
    endsequence
    sequence s_idle_pair;
        (!ack_any && ack_lock) [*2];
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_ack_exclusive: assert property (!(cascade_ack_out_a && cascade_ack_out_b))
        else $error("both acknowledge pins active");
    a_ack_status: assert property (ack_any |-> bus_status_lines == 3'h0)
        else $error("no acknowledge status during acknowledge");
    a_idle_status: assert property (!ack_any |-> bus_status_lines == 3'h7)
        else $error("status lines not passive outside acknowledge");
    a_ack_locked: assert property (ack_any |-> ack_lock)
        else $error("acknowledge cycle without lock");
    a_lock_start: assert property ($rose(ack_lock) |-> $rose(ack_any))
        else $error("lock rose without acknowledge");
    a_ack_len_a: assert property ($rose(cascade_ack_out_a) |-> s_ack_a)
        else $error("acknowledge a shorter than four clocks");
    a_ack_len_b: assert property ($rose(cascade_ack_out_b) |-> s_ack_b)
        else $error("acknowledge b shorter than four clocks");
    a_two_idle_gap: assert property ($fell(ack_any) && ack_lock |-> s_idle_pair ##1 ack_any)
        else $error("gap between acknowledge cycles is not two idles");
    a_wait_ready: assert property (ack_any && !ack_ready |=> ack_any)
        else $error("acknowledge ended while ready withheld");
    a_ack_pin_mode: assert property ((!cascade_ack_out_a || cascade_ack_oe_a) && (!cascade_ack_out_b || cascade_ack_oe_b))
        else $error("acknowledge pulse on a pin not in cascade mode");
endmodule

// file: testbench/test_master_mode_irq_sources_response.sv
`timescale 1ns/100ps
`include "irq_ctrl_map.svh"
module test_master_mode_irq_sources_response;
    import irq_ctrl_pkg::*;
    logic        sys_clk_i    = 1'b0;
    logic        sys_rst_i    = 1'b1;
    logic [3:0]  reg_addr     = 4'h0;
    logic [15:0] reg_wdata    = 16'h0000;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [15:0] reg_rdata;
    logic [2:0]  timer_evt    = 3'h0;
    logic [1:0]  dma_evt      = 2'h0;
    logic        bus_busy     = 1'b0;
    logic        vec_valid;
    vec_addr_t   vec_addr;
    vec_type_t   vec_type;
    logic [3:0]  direct_level = 4'h0;
    logic [1:0]  slave_req    = 2'h0;
    vec_type_t   type_a       = 8'h47;
    vec_type_t   type_b       = 8'h5c;
    logic        ready_hold   = 1'b0;
    int          fail_count   = 0;
    int          checks       = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    irq_link_if link ();
    irq_master_ctrl #(.RESP_INT_CLK(4), .CASC_TAIL_CLK(2)) irq_master_ctrl_i (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link.dev),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .timer_evt_i(timer_evt),
        .dma_evt_i(dma_evt), .bus_busy_i(bus_busy), .vec_valid_o(vec_valid),
        .vec_addr_o(vec_addr), .vec_type_o(vec_type));
    irq_far_end irq_far_end_i (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link.far),
        .direct_level_i(direct_level), .slave_req_i(slave_req),
        .slave_type_a_i(type_a), .slave_type_b_i(type_b),
        .ready_hold_i(ready_hold), .slave_pend_o(), .block_bus_o());
    irq_link_asserts irq_link_asserts_i (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .cascade_ack_out_a(link.cascade_ack_out_a), .cascade_ack_oe_a(link.cascade_ack_oe_a),
        .cascade_ack_out_b(link.cascade_ack_out_b), .cascade_ack_oe_b(link.cascade_ack_oe_b),
        .bus_status_lines(link.bus_status_lines), .ack_lock(link.ack_lock),
        .ack_ready(link.ack_ready));
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        @(negedge sys_clk_i);
        chk(reg_rdata, exp);
        @(posedge sys_clk_i);
    endtask
    task automatic evt(input logic [2:0] t, input logic [1:0] d);
        @(posedge sys_clk_i);
        timer_evt <= t;
        dma_evt <= d;
        @(posedge sys_clk_i);
        timer_evt <= 3'h0;
        dma_evt <= 2'h0;
    endtask
    // vector pulse lasts one cycle, so poll every cycle and never in between
    task automatic wait_vec(input vec_type_t t);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (vec_valid !== 1'b1 && n < 300);
        chk({15'h0000, vec_valid}, 16'h0001);
        chk({8'h00, vec_type}, {8'h00, t});
        chk({6'h00, vec_addr}, {6'h00, t, 2'b00});
        @(posedge sys_clk_i);
    endtask
    task automatic no_vec(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge sys_clk_i);
            seen = seen | vec_valid;
        end
        chk({15'h0000, seen}, 16'h0000);
        @(posedge sys_clk_i);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(`REG_REQUEST, 16'h0000);
        rd(`REG_PRI_MASK, 16'h0007);
        rd(`REG_CTL_BASE, 16'h000f);
        rd(`REG_MODE, 16'h0000);
        wr(4'hE, 16'hffff);
        rd(4'hE, 16'h0000);
        done("reset");
        evt(3'h0, 2'b01);
        rd(`REG_REQUEST, 16'h0002);
        wr(`REG_REQUEST, 16'h0004);
        rd(`REG_REQUEST, 16'h0004);
        wr(`REG_REQUEST, 16'h0000);
        rd(`REG_REQUEST, 16'h0000);
        done("dma latch");
        evt(3'b110, 2'h0);
        rd(`REG_REQUEST, 16'h0001);
        rd(`REG_TIMER_STAT, 16'h0006);
        bus_busy <= 1'b1;
        wr(`REG_CTL_BASE, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        bus_busy <= 1'b0;
        no_vec(3);
        wait_vec(`VT_TMR1);
        rd(`REG_IN_SERVICE, 16'h0001);
        rd(`REG_TIMER_STAT, 16'h0004);
        no_vec(20);
        wr(`REG_EOI, 16'h8000);
        no_vec(4);
        wait_vec(`VT_TMR2);
        rd(`REG_LAST_VEC, 16'h004c);
        wr(`REG_EOI, 16'h8000);
        rd(`REG_IN_SERVICE, 16'h0000);
        wr(`REG_CTL_BASE, 16'h000f);
        done("timers");
        wr(`REG_PRI_MASK, 16'h0000);
        wr(4'h6, 16'h0001);
        wr(4'h7, 16'h0001);
        evt(3'h0, 2'b11);
        no_vec(10);
        wr(`REG_PRI_MASK, 16'h0007);
        wait_vec(`VT_DMA0);
        wait_vec(`VT_DMA1);
        wr(`REG_EOI, 16'h0001);
        wr(`REG_EOI, 16'h0002);
        rd(`REG_IN_SERVICE, 16'h0000);
        done("equal priority");
        wr(4'hA, 16'h0010);
        @(posedge sys_clk_i);
        direct_level <= 4'h4;
        no_vec(20);
        wr(`REG_MODE, 16'h0001);
        wait_vec(`VT_EXT_C);
        rd(`REG_REQUEST, 16'h0020);
        wr(`REG_EOI, 16'h8000);
        wait_vec(`VT_EXT_C);
        direct_level <= 4'h0;
        repeat (3) @(posedge sys_clk_i);
        wr(`REG_EOI, 16'h8000);
        rd(`REG_REQUEST, 16'h0000);
        wr(4'hA, 16'h000f);
        wr(4'hB, 16'h0000);
        direct_level <= 4'h8;
        wait_vec(`VT_EXT_D);
        wr(`REG_EOI, 16'h8000);
        no_vec(15);
        direct_level <= 4'h0;
        repeat (2) @(posedge sys_clk_i);
        direct_level <= 4'h8;
        wait_vec(`VT_EXT_D);
        direct_level <= 4'h0;
        wr(`REG_EOI, 16'h8000);
        wr(4'hB, 16'h000f);
        done("direct inputs");
        wr(4'h8, 16'h0030);
        ready_hold <= 1'b1;
        fork
            begin
                repeat (14) @(posedge sys_clk_i);
                ready_hold <= 1'b0;
            end
        join_none
        evt(3'h0, 2'h0);
        slave_req <= 2'b01;
        @(posedge sys_clk_i);
        slave_req <= 2'b00;
        wait_vec(8'h47);
        wr(`REG_EOI, 16'h0003);
        wr(4'h9, 16'h0030);
        slave_req <= 2'b10;
        @(posedge sys_clk_i);
        slave_req <= 2'b00;
        wait_vec(8'h5c);
        wr(`REG_EOI, 16'h0004);
        rd(`REG_IN_SERVICE, 16'h0000);
        done("cascade");
        tally_and_finish();
    end
endmodule
